// ==== lcdw_pkg.sv ====
// Contract
// [RULE1] 1:3 mode: backplane 3 copies backplane 1
// [RULE2] 1:2 mode: bp2 copies bp0, bp3 copies bp1
// [RULE3] Static mode: all backplanes carry one signal
// [RULE4] 160 segments from phase and display register
// [RULE5] Display RAM 160 x 4, 1 means on
// [RULE6] Rows map to backplanes, columns to segments
// [RULE7] Data bytes stored on arrival, no acknowledge wait
// [RULE8] Static: byte fills row 0, eight columns
// [RULE9] 1:2: four 2-bit words, rows 0-1
// [RULE10] 1:3: three 3-bit words, last row2 untouched
// [RULE11] 1:4: two 4-bit words, rows 0-3
// [RULE12] Byte stored at loaded data pointer address
// [RULE13] Pointer advances 8, 4, 3 or 2
// [RULE14] Host reloads pointer after aborted transfer
// [RULE15] Write only when subaddress counter matches pins
// [RULE16] Cascade-select command loads subaddress counter
// [RULE17] Mismatch suppresses write, pointer still advances
// [RULE18] Pointer overflow increments subaddress counter
// [RULE19] Host keeps subaddress pins stable during access
// [RULE20] Host rewrites 1:3 byte pairs for full fill
// [RULE21] Bank selector cycles rows per multiplex mode
// [RULE22] Drive mode comes from drive-configuration command
// [RULE23] Host waits 1 ms after power-on
// [RULE24] Pointer wraps past column 159 to 0
// [RULE25] Static selects row 0; 1:2 alternates rows
package lcdw_pkg;
    localparam int unsigned COLUMNS    = 160;
    localparam int unsigned ROWS       = 4;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned FIFO_DEPTH = 32;

    localparam logic [7:0] LAST_COL    = 8'h009F;
    localparam logic [7:0] RST_POINTER = 8'h0000;
    localparam logic [1:0] RST_SUBADDR = 2'h0;

    // Drive mode codes
    localparam logic [1:0] MODE_STATIC = 2'h0;
    localparam logic [1:0] MODE_DUP    = 2'h1;
    localparam logic [1:0] MODE_TRI    = 2'h2;
    localparam logic [1:0] MODE_QUAD   = 2'h3;
    localparam logic [1:0] RST_MODE    = MODE_QUAD;

    // Multiplex phase time and its length in clock cycles
    localparam int unsigned CLK_MHZ          = 50;
    localparam int unsigned MUX_PHASE_US     = 3125;
    localparam int unsigned MUX_PHASE_CYCLES = MUX_PHASE_US * CLK_MHZ;
endpackage

// ==== lcdw_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdw_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Flags are registered so the ready seen by the source is a flop
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count     <= next_count;
            in_ready  <= (next_count != (AW + 1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule
`default_nettype wire

// ==== lcdw_ram_writer.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdw_ram_writer #(
    parameter int unsigned MUX_PHASE_CYCLES = lcdw_pkg::MUX_PHASE_CYCLES
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         byte_valid,
    input  wire logic [7:0]   byte_data,
    output logic              byte_ready,
    input  wire logic         ptr_load,
    input  wire logic [7:0]   ptr_value,
    input  wire logic         subaddr_load,
    input  wire logic [1:0]   subaddr_value,
    input  wire logic         mode_load,
    input  wire logic [1:0]   mode_value,
    input  wire logic         subaddr_pin_low,
    input  wire logic         subaddr_pin_high,
    output logic              writer_busy,
    output logic [7:0]        data_pointer,
    output logic [1:0]        subaddr_count,
    output logic [1:0]        drive_mode,
    output logic              backplane_out_0,
    output logic              backplane_out_1,
    output logic              backplane_out_2,
    output logic              backplane_out_3,
    output logic [159:0]      segment_outputs
);
    typedef enum logic {S_IDLE, S_WRITE} lcdw_state_t;

    lcdw_state_t  state;
    logic [1:0]   pin_meta;
    logic [1:0]   pin_sync;
    logic         fifo_valid;
    logic [7:0]   fifo_data;
    logic         fifo_take;
    logic [7:0]   word_sh;
    logic [2:0]   word_idx;
    logic [1:0]   byte_mode;
    logic [2:0]   row_cnt;
    logic [3:0]   words_per_byte;
    logic         last_word;
    logic         sub_match;
    logic         wr_en;
    logic [3:0]   wr_mask;
    logic [3:0]   wr_data;
    logic [3:0]   ram [0:159];
    logic [31:0]  div_cnt;
    logic         mux_tick;
    logic [1:0]   phase;
    logic [1:0]   next_phase;
    logic [2:0]   mode_rows;
    logic [159:0] row_bits;
    logic [3:0]   next_bp;

    // Pins come from outside the clock domain
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end
        else
        begin
            pin_meta <= {subaddr_pin_high, subaddr_pin_low};
            pin_sync <= pin_meta;
        end
    end

    lcdw_fifo #(
        .WIDTH (lcdw_pkg::BYTE_W),
        .DEPTH (lcdw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (byte_valid),
        .in_ready  (byte_ready),
        .in_data   (byte_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take),
        .out_data  (fifo_data)
    );

    // A queued byte is unpacked once the writer is idle, no acknowledge wait
    assign fifo_take = fifo_valid && (state == S_IDLE); // [RULE7]

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drive_mode <= lcdw_pkg::RST_MODE;
        end
        else if (mode_load)
        begin
            drive_mode <= mode_value; // [RULE22]
        end
    end

    // Rows per word and words per byte for the mode the byte started in
    always_comb
    begin
        row_cnt        = 3'd4;
        words_per_byte = 4'd2;
        case (byte_mode)
            lcdw_pkg::MODE_STATIC:
            begin
                row_cnt        = 3'd1;
                words_per_byte = 4'd8; // [RULE8] [RULE13]
            end
            lcdw_pkg::MODE_DUP:
            begin
                row_cnt        = 3'd2;
                words_per_byte = 4'd4; // [RULE9] [RULE13]
            end
            lcdw_pkg::MODE_TRI:
            begin
                row_cnt        = 3'd3;
                words_per_byte = 4'd3; // [RULE10] [RULE13]
            end
            default:
            begin
                row_cnt        = 3'd4;
                words_per_byte = 4'd2; // [RULE11] [RULE13]
            end
        endcase
    end

    assign last_word = ({1'b0, word_idx} == words_per_byte - 4'd1);

    // Pins are trusted stable while a byte is written
    assign sub_match = (subaddr_count == pin_sync); // [RULE15] [RULE19]
    assign wr_en     = (state == S_WRITE) && sub_match; // [RULE17]

    always_comb
    begin
        wr_mask = 4'h0;
        for (int r = 0; r < 4; r++)
        begin
            wr_mask[r] = (3'(r) < row_cnt);
            wr_data[r] = word_sh[7 - r];
        end
        if (byte_mode == lcdw_pkg::MODE_TRI && last_word)
        begin
            wr_mask[2] = 1'b0; // [RULE10]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state       <= S_IDLE;
            word_sh     <= 8'h00;
            word_idx    <= 3'd0;
            byte_mode   <= lcdw_pkg::RST_MODE;
            writer_busy <= 1'b0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (fifo_take)
                    begin
                        word_sh     <= fifo_data;
                        word_idx    <= 3'd0;
                        byte_mode   <= drive_mode;
                        state       <= S_WRITE;
                        writer_busy <= 1'b1;
                    end
                end
                S_WRITE:
                begin
                    word_sh  <= word_sh << row_cnt;
                    word_idx <= word_idx + 3'd1;
                    if (last_word)
                    begin
                        state       <= S_IDLE;
                        writer_busy <= 1'b0;
                    end
                end
                default:
                begin
                    state       <= S_IDLE;
                    writer_busy <= 1'b0;
                end
            endcase
        end
    end

    // One column per cycle; a byte moves the pointer by its word count
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            data_pointer <= lcdw_pkg::RST_POINTER;
        end
        else if (ptr_load)
        begin
            data_pointer <= ptr_value; // [RULE12]
        end
        else if (state == S_WRITE)
        begin
            if (data_pointer >= lcdw_pkg::LAST_COL)
            begin
                data_pointer <= 8'h00; // [RULE24]
            end
            else
            begin
                data_pointer <= data_pointer + 8'h01; // [RULE13] [RULE17]
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            subaddr_count <= lcdw_pkg::RST_SUBADDR;
        end
        else if (subaddr_load)
        begin
            subaddr_count <= subaddr_value; // [RULE16]
        end
        else if (state == S_WRITE && !ptr_load && data_pointer >= lcdw_pkg::LAST_COL)
        begin
            subaddr_count <= subaddr_count + 2'd1; // [RULE18]
        end
    end

    // Memory has no reset; contents are undefined until written
    always_ff @(posedge mclk)
    begin
        if (wr_en && data_pointer <= lcdw_pkg::LAST_COL)
        begin
            for (int r = 0; r < 4; r++)
            begin
                if (wr_mask[r])
                begin
                    ram[data_pointer][r] <= wr_data[r]; // [RULE5] [RULE6]
                end
            end
        end
    end

    // Multiplex instant divider
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt  <= 32'h0000_0000;
            mux_tick <= 1'b0;
        end
        else if (div_cnt >= MUX_PHASE_CYCLES - 1)
        begin
            div_cnt  <= 32'h0000_0000;
            mux_tick <= 1'b1;
        end
        else
        begin
            div_cnt  <= div_cnt + 32'h0000_0001;
            mux_tick <= 1'b0;
        end
    end

    always_comb
    begin
        case (drive_mode)
            lcdw_pkg::MODE_STATIC: mode_rows = 3'd1;
            lcdw_pkg::MODE_DUP:    mode_rows = 3'd2;
            lcdw_pkg::MODE_TRI:    mode_rows = 3'd3;
            default:               mode_rows = 3'd4;
        endcase
        if ({1'b0, phase} + 3'd1 >= mode_rows)
        begin
            next_phase = 2'd0; // [RULE21] [RULE25]
        end
        else
        begin
            next_phase = phase + 2'd1;
        end
    end

    // Row of every column for the coming phase
    for (genvar c = 0; c < lcdw_pkg::COLUMNS; c++)
    begin : g_col
        assign row_bits[c] = ram[c][next_phase]; // [RULE6]
    end

    // Bit k drives backplane k
    always_comb
    begin
        case (drive_mode)
            lcdw_pkg::MODE_STATIC:
            begin
                next_bp = 4'hF; // [RULE3]
            end
            lcdw_pkg::MODE_DUP:
            begin
                next_bp = {next_phase == 2'd1, next_phase == 2'd0,
                           next_phase == 2'd1, next_phase == 2'd0}; // [RULE2]
            end
            lcdw_pkg::MODE_TRI:
            begin
                next_bp = {next_phase == 2'd1, next_phase == 2'd2,
                           next_phase == 2'd1, next_phase == 2'd0}; // [RULE1]
            end
            default:
            begin
                next_bp = 4'h1 << next_phase;
            end
        endcase
    end

    // Display register reloads once per instant, so writes show next phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phase           <= 2'd0;
            segment_outputs <= '0;
            backplane_out_0 <= 1'b0;
            backplane_out_1 <= 1'b0;
            backplane_out_2 <= 1'b0;
            backplane_out_3 <= 1'b0;
        end
        else if (mux_tick)
        begin
            phase           <= next_phase;
            segment_outputs <= row_bits; // [RULE4]
            backplane_out_0 <= next_bp[0];
            backplane_out_1 <= next_bp[1];
            backplane_out_2 <= next_bp[2];
            backplane_out_3 <= next_bp[3];
        end
    end
endmodule
`default_nettype wire

// ==== lcdw_ram_writer_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdw_ram_writer_checker #(
    parameter int unsigned MUX_PHASE_CYCLES = 8
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       ptr_load,
    input wire logic [7:0] ptr_value,
    input wire logic       subaddr_load,
    input wire logic [1:0] subaddr_value,
    input wire logic       mode_load,
    input wire logic [1:0] mode_value,
    input wire logic       writer_busy,
    input wire logic [7:0] data_pointer,
    input wire logic [1:0] subaddr_count,
    input wire logic [1:0] drive_mode,
    input wire logic       backplane_out_0,
    input wire logic       backplane_out_1,
    input wire logic       backplane_out_2,
    input wire logic       backplane_out_3
);
    wire [3:0] bp = {backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Backplanes follow the mode that was in force at the tick, hence $past
    chk_tri_bp_copy: assert property (
        $changed(bp) && $past(drive_mode) == lcdw_pkg::MODE_TRI |-> bp[3] == bp[1])
        else $error("bp3 not bp1");
    chk_dup_bp_copy: assert property (
        $changed(bp) && $past(drive_mode) == lcdw_pkg::MODE_DUP
        |-> bp[2] == bp[0] && bp[3] == bp[1] && bp[0] != bp[1]) else $error("dup bp");
    chk_static_bp_all: assert property (
        $changed(bp) && $past(drive_mode) == lcdw_pkg::MODE_STATIC |-> bp == 4'hf)
        else $error("static bp");
    chk_quad_bp_onehot: assert property (
        $changed(bp) && $past(drive_mode) == lcdw_pkg::MODE_QUAD |-> $onehot(bp))
        else $error("quad bp");
    chk_busy_quad_len: assert property (
        $rose(writer_busy) && drive_mode == lcdw_pkg::MODE_QUAD
        |-> writer_busy [*2] ##1 !writer_busy) else $error("busy length");
    chk_ptr_step: assert property (
        writer_busy && !ptr_load && data_pointer < lcdw_pkg::LAST_COL
        |=> data_pointer == $past(data_pointer) + 8'h01) else $error("ptr step");
    chk_ptr_wrap: assert property (
        writer_busy && !ptr_load && !subaddr_load && data_pointer == lcdw_pkg::LAST_COL
        |=> data_pointer == 8'h00 && subaddr_count == $past(subaddr_count) + 2'h1)
        else $error("ptr wrap");
    chk_ptr_load: assert property (
        ptr_load |=> data_pointer == $past(ptr_value)) else $error("ptr load");
    chk_sub_load: assert property (
        subaddr_load |=> subaddr_count == $past(subaddr_value)) else $error("sub load");
    chk_mode_load: assert property (
        mode_load |=> drive_mode == $past(mode_value)) else $error("mode load");
endmodule
bind lcdw_ram_writer lcdw_ram_writer_checker #(.MUX_PHASE_CYCLES(MUX_PHASE_CYCLES)) chk (
    .mclk, .rst, .ptr_load, .ptr_value, .subaddr_load, .subaddr_value, .mode_load,
    .mode_value, .writer_busy, .data_pointer, .subaddr_count, .drive_mode,
    .backplane_out_0, .backplane_out_1, .backplane_out_2, .backplane_out_3);
`default_nettype wire

// ==== lcdw_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcdw_host (
    input  wire logic       mclk,
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    input  wire logic       byte_ready
);
    logic [7:0] q [$];
    int         gap = 0;
    initial
    begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        forever
        begin
            // Bench queues bytes only after reset has finished
            while (q.size() == 0) @(posedge mclk);
            @(posedge mclk);
            #1;
            byte_valid = 1'b1;
            byte_data = q.pop_front();
            while (byte_ready !== 1'b1)
            begin
                @(posedge mclk);
                #1;
            end
            @(posedge mclk);
            #1;
            byte_valid = 1'b0;
            // Stale data must not look like a fresh byte
            byte_data = ~byte_data;
            repeat (gap) @(posedge mclk);
        end
    end
endmodule
`default_nettype wire

// ==== lcd_display_ram_writer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_display_ram_writer_tb_top;
    logic         mclk, rst, byte_valid, byte_ready, ptr_load, subaddr_load, mode_load;
    logic         subaddr_pin_low, subaddr_pin_high, writer_busy, busy_q, saw_full;
    logic         backplane_out_0, backplane_out_1, backplane_out_2, backplane_out_3;
    logic [7:0]   byte_data, ptr_value, data_pointer, m_ptr;
    logic [1:0]   subaddr_value, mode_value, subaddr_count, drive_mode, m_sub, m_mode;
    logic [159:0] segment_outputs;
    logic [159:0] exp_row [4];
    logic [9:0]   notes [$];
    int           n_fail, checked, seed;
    wire [3:0] bp = {backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};
    lcdw_ram_writer #(.MUX_PHASE_CYCLES(8)) dut (.mclk, .rst, .byte_valid, .byte_data,
        .byte_ready, .ptr_load, .ptr_value, .subaddr_load, .subaddr_value, .mode_load,
        .mode_value, .subaddr_pin_low, .subaddr_pin_high, .writer_busy, .data_pointer,
        .subaddr_count, .drive_mode, .backplane_out_0, .backplane_out_1, .backplane_out_2,
        .backplane_out_3, .segment_outputs);
    lcdw_host host (.mclk, .byte_valid, .byte_data, .byte_ready);
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic cmp_row(string w, logic [159:0] e, logic [159:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic cmp_st(string w, logic [11:0] e, logic [11:0] g);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic cmd(int k, logic [7:0] v);
        @(posedge mclk);
        #1;
        ptr_value = v;
        subaddr_value = v[1:0];
        mode_value = v[1:0];
        ptr_load = (k == 0);
        subaddr_load = (k == 1);
        mode_load = (k == 2);
        if (k == 0) m_ptr = v;
        if (k == 1) m_sub = v[1:0];
        if (k == 2) m_mode = v[1:0];
        @(posedge mclk);
        #1;
        {ptr_load, subaddr_load, mode_load} = 3'h0;
    endtask
    task automatic send(logic [7:0] b);
        int bi;
        bi = 7;
        while (bi >= 0)
        begin
            for (int r = 0; r <= m_mode && bi >= 0; r++)
            begin
                if (m_sub == {subaddr_pin_high, subaddr_pin_low})
                    exp_row[r][m_ptr] = b[bi];
                bi--;
            end
            if (m_ptr == 8'h9f)
            begin
                m_ptr = 8'h00;
                m_sub++;
            end
            else
                m_ptr++;
        end
        notes.push_back({m_ptr, m_sub});
        host.q.push_back(b);
    endtask
    task automatic idle();
        int n, k;
        n = 0;
        k = 0;
        while (n < 4 && k < 2000)
        begin
            @(posedge mclk);
            #1;
            k++;
            n = (writer_busy || byte_valid || host.q.size() > 0) ? 0 : n + 1;
        end
        // A writer that never settles is a failure, not a silent pass
        if (n < 4)
            n_fail++;
    endtask
    task automatic rows(string t);
        int k;
        cmd(2, 8'h03);
        repeat (9) @(posedge mclk);
        #1;
        for (int r = 0; r < 4; r++)
        begin
            k = 0;
            while (bp !== 4'(1 << r) && k < (r == 0 ? 40 : 9))
            begin
                @(posedge mclk);
                #1;
                k++;
            end
            cmp_st("bp", 12'(1 << r), {8'h00, bp});
            cmp_row("row", exp_row[r], segment_outputs);
        end
        $display("test %s done", t);
    endtask
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        #1;
        // Only a byte held off by a full queue counts; ready is low in reset too
        if (byte_ready === 1'b0 && byte_valid === 1'b1) saw_full = 1'b1;
        if (busy_q === 1'b1 && writer_busy === 1'b0)
            cmp_st("ptr", {2'h0, notes.pop_front()}, {2'h0, data_pointer, subaddr_count});
        busy_q = writer_busy;
    end
    // Whole run is about a thousand cycles; this allows ample slack
    initial
    begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial
    begin
        seed = 32'h1f6e_ab86;
        {rst, ptr_load, subaddr_load, mode_load, busy_q, saw_full} = 6'h20;
        {ptr_value, subaddr_value, mode_value, subaddr_pin_low, subaddr_pin_high} = 14'h0;
        {n_fail, checked, m_ptr, m_sub, m_mode} = {64'h0, 12'h003};
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        @(posedge mclk);
        #1;
        cmp_st("reset", 12'h003, {data_pointer, subaddr_count, drive_mode});
        // Input outruns the 1:4 unpacker by one byte in six cycles: enough to fill
        repeat (128) send(8'($random(seed)));
        idle();
        cmp_st("full", 12'h001, {11'h0, saw_full});
        rows("fill");
        cmd(0, 8'h0a);
        send(8'($random(seed)));
        send(8'($random(seed)));
        idle();
        rows("mismatch");
        for (int m = 0; m < 4; m++)
        begin
            cmd(1, 8'h00);
            cmd(2, 8'(m));
            cmd(0, 8'({$random(seed)} % 150));
            host.gap = m;
            send(8'($random(seed)));
            if (m == 2)
            begin
                idle();
                cmd(0, m_ptr - 8'h01);
            end
            send(8'($random(seed)));
            idle();
            if (m == 0)
            begin
                repeat (9) @(posedge mclk);
                #1;
                cmp_row("static", exp_row[0], segment_outputs);
                cmp_st("bp", 12'h00f, {8'h00, bp});
            end
            rows("mode");
        end
        // Pins change only while the writer is idle
        {subaddr_pin_high, subaddr_pin_low} = 2'h2;
        cmd(1, 8'h01);
        cmd(0, 8'h9f);
        send(8'($random(seed)));
        idle();
        rows("cascade");
        complete_run();
    end
endmodule
`default_nettype wire
